/* hdl/sfrpw_pkg.sv */
package sfrpw_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [4:0] PAGE_SEL_OFS = 5'h00;
  localparam logic [4:0] PASSWORD_OFS = 5'h04;
  localparam logic [4:0] SLOT_VIEW_OFS = 5'h08;
  localparam logic [4:0] CLOCK_CTRL_OFS = 5'h0C;
  localparam logic [4:0] POWER_CTRL_OFS = 5'h10;

  // ****************************************************************
  // page select fields
  // ****************************************************************
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 6;
  localparam int SLOT_SEL_MSB = 5;
  localparam int SLOT_SEL_LSB = 4;
  localparam int PAGE_RSVD_BIT = 3;
  localparam int PAGE_MSB = 2;
  localparam int PAGE_LSB = 0;
  localparam int PAGE_W = 3;
  localparam int SLOT_SEL_W = 2;
  localparam int SLOT_NUM = 4;
  localparam logic [2:0] PAGE_RST = 3'h0;
  localparam logic [2:0] SLOT_RST = 3'h0;

  // ****************************************************************
  // password register fields and codes
  // ****************************************************************
  localparam int PASS_MSB = 7;
  localparam int PASS_LSB = 3;
  localparam int OPEN_STAT_BIT = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;
  localparam logic [4:0] PASS_OPEN = 5'h13;
  localparam logic [4:0] PASS_CLOSE = 5'h15;
  localparam logic [4:0] PASS_MODE = 5'h18;
  localparam logic [1:0] MODE_PROTECT = 2'h3;
  localparam logic [1:0] MODE_RST = 2'h3;

  // ****************************************************************
  // protected and free control fields
  // ****************************************************************
  localparam int FB_DIV_MSB = 3;
  localparam int FB_DIV_LSB = 0;
  localparam int OUT_DIV_MSB = 5;
  localparam int OUT_DIV_LSB = 4;
  localparam int CLKOUT_EN_BIT = 7;
  localparam int PD_BIT = 0;
  localparam int SD_BIT = 1;
  localparam int WDT_BIT = 2;
  localparam int WAKE_MSB = 7;
  localparam int WAKE_LSB = 4;
  localparam logic [3:0] FB_DIV_RST = 4'h0;
  localparam logic [1:0] OUT_DIV_RST = 2'h0;
  localparam logic [3:0] WAKE_RST = 4'h0;
  localparam logic CLKOUT_EN_RST = 1'h0;
  localparam logic PD_RST = 1'h0;
  localparam logic SD_RST = 1'h0;
  localparam logic WDT_RST = 1'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int OPEN_WINDOW_CYCLES = 32;
  localparam int OPEN_CNT_W = 6;

  // ****************************************************************
  // bus handshake states
  // ****************************************************************
  typedef enum logic [1:0] {
    SFRPW_BUS_IDLE = 2'b01,
    SFRPW_BUS_ACK = 2'b10
  } sfrpw_bus_state_type;

endpackage

/* hdl/sfrpw_open_timer.sv */
module sfrpw_open_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic open_i,
  input wire logic close_i,
  input wire logic bypass_i,
  output logic open_o
);

  logic [sfrpw_pkg::OPEN_CNT_W-1:0] cnt_q;
  logic [sfrpw_pkg::OPEN_CNT_W-1:0] cnt_d;

  // ****************************************************************
  // window counter
  // ****************************************************************
  always_comb begin
    cnt_d = cnt_q;
    if (close_i) begin
      cnt_d = '0;
    // (R10) open again restarts
    end else if (open_i) begin
      cnt_d = sfrpw_pkg::OPEN_CNT_W'(sfrpw_pkg::OPEN_WINDOW_CYCLES);
    // (R9) automatic close countdown
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_o <= 1'b0;
    end else begin
      open_o <= bypass_i || (cnt_d != '0);
    end
  end

endmodule

/* hdl/sfrpw_top.sv */
// Function
// (R1) op 0X writes page directly
// (R2) op 10 writes page, saves old
// (R3) op 11 restores page from slot
// (R4) bit 3 reads zero, write zero
// (R5) mode 11: code 10011 opens access
// (R6) mode 11: code 10101 closes access
// (R7) open/close codes keep mode unchanged
// (R8) only code 11000 changes mode
// (R9) access closes after 32 cycles
// (R10) reopening restarts the 32 count
// (R11) dividers, watchdog, powerdown, slowdown protected
// (R12) closed: protected dropped, others written
module sfrpw_top (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [sfrpw_pkg::ADDR_W-1:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [sfrpw_pkg::BE_W-1:0] BYTEENABLE_I,
  input wire logic [sfrpw_pkg::DATA_W-1:0] WRITEDATA_I,
  output logic [sfrpw_pkg::DATA_W-1:0] READDATA_O,
  output logic WAITREQUEST_O,
  output logic [sfrpw_pkg::PAGE_W-1:0] PAGE_O,
  output logic ACCESS_OPEN_O,
  output logic [3:0] FEEDBACK_DIVIDER_O,
  output logic [1:0] OUTPUT_DIVIDER_O,
  output logic WATCHDOG_ENABLE_O,
  output logic POWERDOWN_ENABLE_O,
  output logic SLOWDOWN_ENABLE_O,
  output logic CLOCK_OUT_ENABLE_O,
  output logic [3:0] WAKE_CONFIG_O
);

  // ****************************************************************
  // local types
  // ****************************************************************
  typedef logic [sfrpw_pkg::SLOT_SEL_W-1:0] sfrpw_slot_sel_type;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic hit(input logic [sfrpw_pkg::ADDR_W-1:0] addr,
                               input logic [sfrpw_pkg::ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  sfrpw_pkg::sfrpw_bus_state_type state_q;
  sfrpw_pkg::sfrpw_bus_state_type state_d;

  logic wr_commit;
  logic rd_capture;
  logic wr_low;
  logic [7:0] wbyte;
  logic bus_req;
  logic clk_ctrl_wr;
  logic pwr_ctrl_wr;

  logic [sfrpw_pkg::PAGE_W-1:0] page_q;
  logic [sfrpw_pkg::PAGE_W-1:0] page_d;
  logic [sfrpw_pkg::PAGE_W-1:0] slot_q [sfrpw_pkg::SLOT_NUM];
  logic [sfrpw_pkg::SLOT_NUM*sfrpw_pkg::PAGE_W-1:0] slot_flat;
  logic [1:0] op;
  logic [sfrpw_pkg::SLOT_SEL_W-1:0] slot_sel;
  logic page_wr;
  logic save_slot;

  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic [4:0] pass_code;
  logic pass_wr;
  logic open_req;
  logic close_req;
  logic timer_open;
  logic prot_off;

  logic [sfrpw_pkg::DATA_W-1:0] rdata;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      sfrpw_pkg::SFRPW_BUS_IDLE: begin
        if (bus_req) begin
          state_d = sfrpw_pkg::SFRPW_BUS_ACK;
        end
      end
      sfrpw_pkg::SFRPW_BUS_ACK: begin
        state_d = sfrpw_pkg::SFRPW_BUS_IDLE;
      end
      default: begin
        state_d = sfrpw_pkg::SFRPW_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_q <= sfrpw_pkg::SFRPW_BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      WAITREQUEST_O <= 1'b1;
    end else begin
      WAITREQUEST_O <= (state_d != sfrpw_pkg::SFRPW_BUS_ACK);
    end
  end

  // write lands on the edge that ends the request
  assign wr_commit = WRITE_I && (state_q == sfrpw_pkg::SFRPW_BUS_ACK);
  assign rd_capture = READ_I && (state_q == sfrpw_pkg::SFRPW_BUS_IDLE);
  assign wr_low = wr_commit && BYTEENABLE_I[0];
  assign wbyte = WRITEDATA_I[7:0];
  assign bus_req = READ_I || WRITE_I;

  // ****************************************************************
  // page select and storage slots
  // ****************************************************************
  assign op = wbyte[sfrpw_pkg::OP_MSB:sfrpw_pkg::OP_LSB];
  assign slot_sel = wbyte[sfrpw_pkg::SLOT_SEL_MSB:sfrpw_pkg::SLOT_SEL_LSB];
  assign page_wr = wr_low && hit(ADDRESS_I, sfrpw_pkg::PAGE_SEL_OFS);
  assign save_slot = page_wr && (op == 2'h2);

  always_comb begin
    page_d = page_q;
    if (page_wr) begin
      case (op)
        // (R3) restore from chosen slot
        2'h3: begin
          page_d = slot_q[slot_sel];
        end
        // (R2) new page, old saved
        2'h2: begin
          page_d = wbyte[sfrpw_pkg::PAGE_MSB:sfrpw_pkg::PAGE_LSB];
        end
        // (R1) slot select ignored
        default: begin
          page_d = wbyte[sfrpw_pkg::PAGE_MSB:sfrpw_pkg::PAGE_LSB];
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      page_q <= sfrpw_pkg::PAGE_RST;
    end else begin
      page_q <= page_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      PAGE_O <= sfrpw_pkg::PAGE_RST;
    end else begin
      PAGE_O <= page_d;
    end
  end

  generate
    for (genvar i = 0; i < sfrpw_pkg::SLOT_NUM; i++) begin : g_slot
      // (R2) previous page into slot
      always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
          slot_q[i] <= sfrpw_pkg::SLOT_RST;
        end else if (save_slot && (slot_sel == sfrpw_slot_sel_type'(i))) begin
          slot_q[i] <= page_q;
        end
      end
      assign slot_flat[i*sfrpw_pkg::PAGE_W +: sfrpw_pkg::PAGE_W] = slot_q[i];
    end
  endgenerate

  // ****************************************************************
  // password and protection mode
  // ****************************************************************
  assign pass_code = wbyte[sfrpw_pkg::PASS_MSB:sfrpw_pkg::PASS_LSB];
  assign pass_wr = wr_low && hit(ADDRESS_I, sfrpw_pkg::PASSWORD_OFS);

  // (R5) open code under mode 11
  assign open_req = pass_wr && (mode_q == sfrpw_pkg::MODE_PROTECT)
                    && (pass_code == sfrpw_pkg::PASS_OPEN);
  // (R6) close code under mode 11
  assign close_req = (pass_wr && (mode_q == sfrpw_pkg::MODE_PROTECT)
                     && (pass_code == sfrpw_pkg::PASS_CLOSE))
                     || (mode_d != mode_q);

  always_comb begin
    mode_d = mode_q;
    // (R8) mode changes only here
    if (pass_wr && (pass_code == sfrpw_pkg::PASS_MODE)) begin
      mode_d = wbyte[sfrpw_pkg::MODE_MSB:sfrpw_pkg::MODE_LSB];
    end
  end

  // (R7) open and close codes skip mode
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      mode_q <= sfrpw_pkg::MODE_RST;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ****************************************************************
  // timed access window
  // ****************************************************************
  // (R8) any mode but 11 leaves access open
  assign prot_off = (mode_d != sfrpw_pkg::MODE_PROTECT);

  sfrpw_open_timer u_open_timer (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .open_i(open_req),
    .close_i(close_req),
    .bypass_i(prot_off),
    .open_o(timer_open)
  );

  assign ACCESS_OPEN_O = timer_open;

  // ****************************************************************
  // protected and free clock controls
  // ****************************************************************
  assign clk_ctrl_wr = wr_low && hit(ADDRESS_I, sfrpw_pkg::CLOCK_CTRL_OFS);

  // (R11) feedback divider needs open access
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      FEEDBACK_DIVIDER_O <= sfrpw_pkg::FB_DIV_RST;
    end else if (clk_ctrl_wr && timer_open) begin
      FEEDBACK_DIVIDER_O <= wbyte[sfrpw_pkg::FB_DIV_MSB:sfrpw_pkg::FB_DIV_LSB];
    end
  end

  // (R11) output divider needs open access
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      OUTPUT_DIVIDER_O <= sfrpw_pkg::OUT_DIV_RST;
    end else if (clk_ctrl_wr && timer_open) begin
      OUTPUT_DIVIDER_O <= wbyte[sfrpw_pkg::OUT_DIV_MSB:sfrpw_pkg::OUT_DIV_LSB];
    end
  end

  // (R12) free bit written regardless
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      CLOCK_OUT_ENABLE_O <= sfrpw_pkg::CLKOUT_EN_RST;
    end else if (clk_ctrl_wr) begin
      CLOCK_OUT_ENABLE_O <= wbyte[sfrpw_pkg::CLKOUT_EN_BIT];
    end
  end

  // ****************************************************************
  // protected and free power controls
  // ****************************************************************
  assign pwr_ctrl_wr = wr_low && hit(ADDRESS_I, sfrpw_pkg::POWER_CTRL_OFS);

  // (R11) powerdown needs open access
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      POWERDOWN_ENABLE_O <= sfrpw_pkg::PD_RST;
    end else if (pwr_ctrl_wr && timer_open) begin
      POWERDOWN_ENABLE_O <= wbyte[sfrpw_pkg::PD_BIT];
    end
  end

  // (R11) slowdown needs open access
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      SLOWDOWN_ENABLE_O <= sfrpw_pkg::SD_RST;
    end else if (pwr_ctrl_wr && timer_open) begin
      SLOWDOWN_ENABLE_O <= wbyte[sfrpw_pkg::SD_BIT];
    end
  end

  // (R11) watchdog enable needs open access
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      WATCHDOG_ENABLE_O <= sfrpw_pkg::WDT_RST;
    end else if (pwr_ctrl_wr && timer_open) begin
      WATCHDOG_ENABLE_O <= wbyte[sfrpw_pkg::WDT_BIT];
    end
  end

  // (R12) free bits written regardless
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      WAKE_CONFIG_O <= sfrpw_pkg::WAKE_RST;
    end else if (pwr_ctrl_wr) begin
      WAKE_CONFIG_O <= wbyte[sfrpw_pkg::WAKE_MSB:sfrpw_pkg::WAKE_LSB];
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rdata = '0;
    case (1'b1)
      hit(ADDRESS_I, sfrpw_pkg::PAGE_SEL_OFS): begin
        // (R4) reserved bit and write-only fields read 0
        rdata[sfrpw_pkg::PAGE_MSB:sfrpw_pkg::PAGE_LSB] = page_q;
      end
      hit(ADDRESS_I, sfrpw_pkg::PASSWORD_OFS): begin
        rdata[sfrpw_pkg::OPEN_STAT_BIT] = timer_open;
        rdata[sfrpw_pkg::MODE_MSB:sfrpw_pkg::MODE_LSB] = mode_q;
      end
      hit(ADDRESS_I, sfrpw_pkg::SLOT_VIEW_OFS): begin
        rdata[sfrpw_pkg::SLOT_NUM*sfrpw_pkg::PAGE_W-1:0] = slot_flat;
      end
      hit(ADDRESS_I, sfrpw_pkg::CLOCK_CTRL_OFS): begin
        rdata[sfrpw_pkg::FB_DIV_MSB:sfrpw_pkg::FB_DIV_LSB] = FEEDBACK_DIVIDER_O;
        rdata[sfrpw_pkg::OUT_DIV_MSB:sfrpw_pkg::OUT_DIV_LSB] = OUTPUT_DIVIDER_O;
        rdata[sfrpw_pkg::CLKOUT_EN_BIT] = CLOCK_OUT_ENABLE_O;
      end
      hit(ADDRESS_I, sfrpw_pkg::POWER_CTRL_OFS): begin
        rdata[sfrpw_pkg::PD_BIT] = POWERDOWN_ENABLE_O;
        rdata[sfrpw_pkg::SD_BIT] = SLOWDOWN_ENABLE_O;
        rdata[sfrpw_pkg::WDT_BIT] = WATCHDOG_ENABLE_O;
        rdata[sfrpw_pkg::WAKE_MSB:sfrpw_pkg::WAKE_LSB] = WAKE_CONFIG_O;
      end
      default: begin
        rdata = '0;
      end
    endcase
  end

  // unmapped addresses read zero
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      READDATA_O <= '0;
    end else if (rd_capture) begin
      READDATA_O <= rdata;
    end
  end

endmodule

/* testbench/sfrpw_top_asserts.sv */
module sfrpw_top_asserts (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [sfrpw_pkg::ADDR_W-1:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [sfrpw_pkg::BE_W-1:0] BYTEENABLE_I,
  input wire logic [sfrpw_pkg::DATA_W-1:0] WRITEDATA_I,
  input wire logic [sfrpw_pkg::DATA_W-1:0] READDATA_O,
  input wire logic WAITREQUEST_O,
  input wire logic [sfrpw_pkg::PAGE_W-1:0] PAGE_O,
  input wire logic ACCESS_OPEN_O,
  input wire logic [3:0] FEEDBACK_DIVIDER_O,
  input wire logic [1:0] OUTPUT_DIVIDER_O,
  input wire logic WATCHDOG_ENABLE_O,
  input wire logic POWERDOWN_ENABLE_O,
  input wire logic SLOWDOWN_ENABLE_O,
  input wire logic CLOCK_OUT_ENABLE_O,
  input wire logic [3:0] WAKE_CONFIG_O
);
  logic wr_ok;
  logic pw_wr;
  logic cl_wr;
  logic rd_ok;
  logic [4:0] code;
  logic [1:0] mode_q;
  logic [5:0] cnt_q;
  assign wr_ok = WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0];
  assign rd_ok = READ_I && !WAITREQUEST_O;
  assign code = WRITEDATA_I[7:3];
  assign pw_wr = wr_ok && ADDRESS_I == sfrpw_pkg::PASSWORD_OFS;
  assign cl_wr = pw_wr && (code == sfrpw_pkg::PASS_CLOSE || code == sfrpw_pkg::PASS_MODE);
  // ********
  // shadow of protection mode and open-window age
  // ********
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      mode_q <= sfrpw_pkg::MODE_RST;
    end else if (pw_wr && code == sfrpw_pkg::PASS_MODE) begin
      mode_q <= WRITEDATA_I[1:0];
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RESET_I || !ACCESS_OPEN_O || mode_q != 2'h3 || (pw_wr && code == sfrpw_pkg::PASS_OPEN)) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  page_direct_a: assert property (
    wr_ok && ADDRESS_I == 5'h00 && !WRITEDATA_I[7] |=> PAGE_O == $past(WRITEDATA_I[2:0]))
    else $error("direct page write not applied");
  page_save_a: assert property (
    wr_ok && ADDRESS_I == 5'h00 && WRITEDATA_I[7:6] == 2'h2 |=> PAGE_O == $past(WRITEDATA_I[2:0]))
    else $error("saving page write not applied");
  rsvd_zero_a: assert property (
    rd_ok && ADDRESS_I == 5'h00 |-> READDATA_O[7:3] == 5'h00)
    else $error("page select upper bits not zero");
  open_win_a: assert property (
    pw_wr && code == sfrpw_pkg::PASS_OPEN |=> ACCESS_OPEN_O)
    else $error("open code did not open access");
  close_now_a: assert property (
    pw_wr && code == sfrpw_pkg::PASS_CLOSE && mode_q == 2'h3 |=> !ACCESS_OPEN_O)
    else $error("close code did not close access");
  mode_keep_a: assert property (
    rd_ok && ADDRESS_I == sfrpw_pkg::PASSWORD_OFS |-> READDATA_O[1:0] == mode_q)
    else $error("mode field changed wrongly");
  auto_close_a: assert property (
    cnt_q <= 6'h20)
    else $error("access open longer than window");
  open_hold_a: assert property (
    ACCESS_OPEN_O && mode_q == 2'h3 && cnt_q < 6'h1F && !cl_wr && !$past(cl_wr) |=> ACCESS_OPEN_O)
    else $error("access closed before window end");
  prot_take_a: assert property (
    wr_ok && ADDRESS_I == 5'h10 && ACCESS_OPEN_O |=>
    {WATCHDOG_ENABLE_O, SLOWDOWN_ENABLE_O, POWERDOWN_ENABLE_O} == $past(WRITEDATA_I[2:0]))
    else $error("open protected write not applied");
  prot_drop_a: assert property (
    wr_ok && ADDRESS_I == 5'h0C && !ACCESS_OPEN_O |=> $stable(FEEDBACK_DIVIDER_O) &&
    $stable(OUTPUT_DIVIDER_O) && CLOCK_OUT_ENABLE_O == $past(WRITEDATA_I[7]))
    else $error("closed clock control write wrong");
  cover property (pw_wr && code == sfrpw_pkg::PASS_OPEN);
  cover property (wr_ok && ADDRESS_I == 5'h00 && WRITEDATA_I[7:6] == 2'h3);
  cover property (cnt_q == 6'h20);
endmodule

bind sfrpw_top sfrpw_top_asserts i_chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I),
  .WRITE_I(WRITE_I), .BYTEENABLE_I(BYTEENABLE_I), .WRITEDATA_I(WRITEDATA_I),
  .READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O), .PAGE_O(PAGE_O),
  .ACCESS_OPEN_O(ACCESS_OPEN_O), .FEEDBACK_DIVIDER_O(FEEDBACK_DIVIDER_O),
  .OUTPUT_DIVIDER_O(OUTPUT_DIVIDER_O), .WATCHDOG_ENABLE_O(WATCHDOG_ENABLE_O),
  .POWERDOWN_ENABLE_O(POWERDOWN_ENABLE_O), .SLOWDOWN_ENABLE_O(SLOWDOWN_ENABLE_O),
  .CLOCK_OUT_ENABLE_O(CLOCK_OUT_ENABLE_O), .WAKE_CONFIG_O(WAKE_CONFIG_O)
);

/* testbench/sfrpw_top_tb.sv */
module sfrpw_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0] a;
    logic [7:0] d;
    logic [4:0] ra;
    logic [7:0] e;
  } sfrpw_row_type;
  logic CLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic [4:0] ADDRESS_I = 5'h00;
  logic READ_I = 1'b0;
  logic WRITE_I = 1'b0;
  logic [3:0] BYTEENABLE_I = 4'hF;
  logic [31:0] WRITEDATA_I = 32'h00000000;
  logic [31:0] READDATA_O;
  logic WAITREQUEST_O;
  logic [2:0] PAGE_O;
  logic ACCESS_OPEN_O;
  logic [3:0] FEEDBACK_DIVIDER_O;
  logic [1:0] OUTPUT_DIVIDER_O;
  logic WATCHDOG_ENABLE_O;
  logic POWERDOWN_ENABLE_O;
  logic SLOWDOWN_ENABLE_O;
  logic CLOCK_OUT_ENABLE_O;
  logic [3:0] WAKE_CONFIG_O;
  int error_cnt = 0;
  int checked = 0;
  int n;
  logic [31:0] q;
  sfrpw_row_type rows [10] = '{
    '{5'h00, 8'h05, 5'h00, 8'h05}, '{5'h00, 8'h72, 5'h00, 8'h02},
    '{5'h00, 8'h96, 5'h08, 8'h10}, '{5'h00, 8'h87, 5'h00, 8'h07}, // bit 3 written 0
    '{5'h00, 8'hD1, 5'h00, 8'h02}, '{5'h00, 8'hC5, 5'h00, 8'h06},
    '{5'h14, 8'hFF, 5'h14, 8'h00}, '{5'h0C, 8'hFF, 5'h0C, 8'h80},
    '{5'h10, 8'hF7, 5'h10, 8'hF0}, '{5'h04, 8'h00, 5'h04, 8'h03}};

  sfrpw_top i_dut (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I),
    .WRITE_I(WRITE_I), .BYTEENABLE_I(BYTEENABLE_I), .WRITEDATA_I(WRITEDATA_I),
    .READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O), .PAGE_O(PAGE_O),
    .ACCESS_OPEN_O(ACCESS_OPEN_O), .FEEDBACK_DIVIDER_O(FEEDBACK_DIVIDER_O),
    .OUTPUT_DIVIDER_O(OUTPUT_DIVIDER_O), .WATCHDOG_ENABLE_O(WATCHDOG_ENABLE_O),
    .POWERDOWN_ENABLE_O(POWERDOWN_ENABLE_O), .SLOWDOWN_ENABLE_O(SLOWDOWN_ENABLE_O),
    .CLOCK_OUT_ENABLE_O(CLOCK_OUT_ENABLE_O), .WAKE_CONFIG_O(WAKE_CONFIG_O)
  );

  always #20 CLK_I = ~CLK_I;

  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    WRITE_I <= wr;
    READ_I <= !wr;
    ADDRESS_I <= a;
    WRITEDATA_I <= {24'h000000, d};
    @(posedge CLK_I);
    while (WAITREQUEST_O !== 1'b0 && k < 20) begin
      @(posedge CLK_I);
      k++;
    end
    chk({31'h00000000, k < 20}, 32'h00000001);
    q = READDATA_O;
    WRITE_I <= 1'b0;
    READ_I <= 1'b0;
    @(posedge CLK_I);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask

  // counts cycles that access stays open
  task automatic win(output int c);
    c = 0;
    while (ACCESS_OPEN_O === 1'b1 && c < 40) begin
      c++;
      @(posedge CLK_I);
    end
  endtask

  function automatic logic [31:0] outs();
    return {13'h0000, WAITREQUEST_O, ACCESS_OPEN_O, PAGE_O, FEEDBACK_DIVIDER_O,
      OUTPUT_DIVIDER_O, WATCHDOG_ENABLE_O, POWERDOWN_ENABLE_O, SLOWDOWN_ENABLE_O,
      CLOCK_OUT_ENABLE_O, WAKE_CONFIG_O};
  endfunction

  task automatic final_report();
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge CLK_I);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    chk(outs(), 32'h00040000);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].ra, rows[i].e);
    end
    BYTEENABLE_I <= 4'h0;
    bus(1'b1, 5'h00, 8'h03);
    BYTEENABLE_I <= 4'hF;
    rd(5'h00, 8'h06);
    bus(1'b1, 5'h04, 8'h98);
    rd(5'h04, 8'h07);
    bus(1'b1, 5'h0C, 8'h3B);
    rd(5'h0C, 8'h3B);
    bus(1'b1, 5'h10, 8'h07);
    rd(5'h10, 8'h07);
    bus(1'b1, 5'h04, 8'hA8);
    rd(5'h04, 8'h03);
    bus(1'b1, 5'h0C, 8'h80);
    rd(5'h0C, 8'hBB);
    bus(1'b1, 5'h04, 8'h98);
    win(n);
    chk(n, 32'h00000020);
    bus(1'b1, 5'h04, 8'h98);
    repeat (20) @(posedge CLK_I);
    bus(1'b1, 5'h04, 8'h98);
    win(n);
    chk(n, 32'h00000020);
    bus(1'b1, 5'h04, 8'hC0);
    rd(5'h04, 8'h04);
    bus(1'b1, 5'h04, 8'h98);
    rd(5'h04, 8'h04);
    bus(1'b1, 5'h0C, 8'h00);
    rd(5'h0C, 8'h00);
    bus(1'b1, 5'h04, 8'hC3);
    rd(5'h04, 8'h03);
    bus(1'b1, 5'h00, 8'h05);
    RESET_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    chk(outs(), 32'h00040000);
    rd(5'h00, 8'h00);
    final_report();
  end
endmodule
